// >>> hw/cpwm_params.svh
// Register offsets, field positions, reset values and the prescaler width of the complementary PWM block.
`ifndef CPWM_PARAMS_SVH
`define CPWM_PARAMS_SVH

`define CPWM_OFF_CONTROL        8'h00
`define CPWM_OFF_OUT_ENABLE     8'h04
`define CPWM_OFF_BUS_CONTROL    8'h08
`define CPWM_OFF_MAIN_COUNT     8'h0C
`define CPWM_OFF_OFFSET_COUNT   8'h10
`define CPWM_OFF_UPPER_LIMIT    8'h14
`define CPWM_OFF_UPPER_BUFFER   8'h18
`define CPWM_OFF_DUTY_CMP1      8'h1C
`define CPWM_OFF_DUTY_CMP2      8'h20
`define CPWM_OFF_DUTY_CMP3      8'h24
`define CPWM_OFF_DUTY_BUF1      8'h28
`define CPWM_OFF_DUTY_BUF2      8'h2C
`define CPWM_OFF_DUTY_BUF3      8'h30
`define CPWM_OFF_DEADTIME       8'h34
`define CPWM_OFF_HALF_CYCLE     8'h38
`define CPWM_OFF_HALF_BUFFER    8'h3C
`define CPWM_OFF_SUBCOUNT       8'h40

`define CPWM_BIT_CH3_RUN        0
`define CPWM_BIT_CH4_RUN        1
`define CPWM_BIT_MODE_SEL       2
`define CPWM_BIT_TOGGLE_EN      3
`define CPWM_BIT_POS_LEVEL      4
`define CPWM_BIT_NEG_LEVEL      5
`define CPWM_BIT_UPD_CREST      6
`define CPWM_BIT_UPD_TROUGH     7
`define CPWM_LSB_PRESCALER      8
`define CPWM_MSB_PRESCALER      10
`define CPWM_BIT_ACCESS_EN      13

`define CPWM_RST_CONTROL        16'h0000
`define CPWM_RST_BUS_CONTROL    16'h2000
`define CPWM_RST_OUT_ENABLE     6'h00
`define CPWM_RST_COUNT          16'h0000
`define CPWM_RST_LIMIT          16'hFFFF

`define CPWM_PRESCALE_BITS      8

`endif

// >>> hw/cpwm_pkg.sv
// Types shared by the complementary PWM block.
package cpwm_pkg;

	typedef struct packed {
		logic [2:0] prescaler_select;
		logic       upd_trough;
		logic       upd_crest;
		logic       negative_level_select;
		logic       positive_level_select;
		logic       period_toggle_enable;
		logic       mode_sel;
		logic       ch4_run_bit;
		logic       ch3_run_bit;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       write;
		logic       valid;
	} bus_req_t;

	typedef enum logic [1:0] {
		SUB_IDLE,
		SUB_CREST,
		SUB_TROUGH
	} sub_phase_t;

endpackage : cpwm_pkg

// >>> hw/complementary_three_phase_pwm.sv
// Three-phase complementary PWM generator with dead time, behind an AHB-Lite register slave.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`include "cpwm_params.svh"

module complementary_three_phase_pwm (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             period_toggle_pin,
	output logic             phase1_positive_out,
	output logic             phase1_negative_out,
	output logic             phase2_positive_out,
	output logic             phase2_negative_out,
	output logic             phase3_positive_out,
	output logic             phase3_negative_out
);

	cpwm_pkg::ctrl_t      ctrl_r;
	cpwm_pkg::bus_req_t   req_r;
	cpwm_pkg::sub_phase_t sub_phase_r;
	logic [15:0] bus_control_register_one_r;
	logic [5:0]  output_master_enable_r;
	logic [15:0] main_updown_counter_r;
	logic [15:0] offset_updown_counter_r;
	logic [15:0] deadtime_subcounter_r;
	logic        main_up_r;
	logic        offset_up_r;
	logic        sub_up_r;
	logic [15:0] upper_limit_register_r;
	logic [15:0] upper_limit_buffer_r;
	logic [15:0] upper_limit_stage_r;
	logic [15:0] deadtime_value_register_r;
	logic [15:0] half_cycle_register_r;
	logic [15:0] half_cycle_buffer_r;
	logic [15:0] half_cycle_stage_r;
	logic [15:0] duty_cmp_r [3];
	logic [15:0] duty_buf_r [3];
	logic [15:0] duty_stage_r [3];
	logic        xfer_pend_r;
	logic        mode_d_r;
	logic        init_hold_r;
	logic [`CPWM_PRESCALE_BITS-1:0] presc_r;
	logic [31:0] hrdata_r;
	logic [5:0]  pins_r;
	logic        toggle_r;

	logic        access_en;
	logic        wr_en;
	logic        running;
	logic        tick;
	logic        mode_rise;
	logic        sub_active;
	logic        crest_start;
	logic        trough_start;
	logic        crest_end;
	logic        trough_end;
	logic        load_cmp;
	logic        do_xfer;
	logic [7:0]  presc_mask;
	logic [15:0] wdata;

	// Registers behind the access-enable bit; buffers and control stay reachable.
	function automatic logic is_guarded(input logic [7:0] a);
		case (a)
			`CPWM_OFF_MAIN_COUNT, `CPWM_OFF_OFFSET_COUNT, `CPWM_OFF_UPPER_LIMIT,
			`CPWM_OFF_DUTY_CMP1, `CPWM_OFF_DUTY_CMP2, `CPWM_OFF_DUTY_CMP3,
			`CPWM_OFF_DEADTIME, `CPWM_OFF_HALF_CYCLE: is_guarded = 1'b1;
			default: is_guarded = 1'b0;
		endcase
	endfunction : is_guarded

	function automatic logic wr_hit(input cpwm_pkg::bus_req_t r, input logic [7:0] a, input logic en);
		wr_hit = r.valid && r.write && (r.addr == a) && (en || !is_guarded(a));
	endfunction : wr_hit

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign wdata     = hwdata[15:0];
	assign access_en = bus_control_register_one_r[`CPWM_BIT_ACCESS_EN];
	assign wr_en     = req_r.valid && req_r.write;

	// The address phase is registered; write data is committed in the following data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r <= '0;
		end else if (hready) begin
			req_r.valid <= hsel && htrans[1];
			req_r.write <= hwrite;
			req_r.addr  <= haddr[7:0];
		end
	end

	// Read data is captured at the address phase so it stands from a flip-flop in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_r <= 32'h00000000;
			if (access_en || !is_guarded(haddr[7:0])) begin
				case (haddr[7:0])
					`CPWM_OFF_CONTROL:      hrdata_r[10:0] <= ctrl_r;
					`CPWM_OFF_OUT_ENABLE:   hrdata_r[5:0]  <= output_master_enable_r;
					`CPWM_OFF_BUS_CONTROL:  hrdata_r[15:0] <= bus_control_register_one_r;
					`CPWM_OFF_MAIN_COUNT:   hrdata_r[15:0] <= main_updown_counter_r;
					`CPWM_OFF_OFFSET_COUNT: hrdata_r[15:0] <= offset_updown_counter_r;
					`CPWM_OFF_UPPER_LIMIT:  hrdata_r[15:0] <= upper_limit_register_r;
					`CPWM_OFF_UPPER_BUFFER: hrdata_r[15:0] <= upper_limit_buffer_r;
					`CPWM_OFF_DUTY_CMP1:    hrdata_r[15:0] <= duty_cmp_r[0];
					`CPWM_OFF_DUTY_CMP2:    hrdata_r[15:0] <= duty_cmp_r[1];
					`CPWM_OFF_DUTY_CMP3:    hrdata_r[15:0] <= duty_cmp_r[2];
					`CPWM_OFF_DUTY_BUF1:    hrdata_r[15:0] <= duty_buf_r[0];
					`CPWM_OFF_DUTY_BUF2:    hrdata_r[15:0] <= duty_buf_r[1];
					`CPWM_OFF_DUTY_BUF3:    hrdata_r[15:0] <= duty_buf_r[2];
					`CPWM_OFF_DEADTIME:     hrdata_r[15:0] <= deadtime_value_register_r;
					`CPWM_OFF_HALF_CYCLE:   hrdata_r[15:0] <= half_cycle_register_r;
					`CPWM_OFF_HALF_BUFFER:  hrdata_r[15:0] <= half_cycle_buffer_r;
					`CPWM_OFF_SUBCOUNT:     hrdata_r[15:0] <= deadtime_subcounter_r;
					default:                hrdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	// Control, enable and bus-control registers are never guarded.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r                     <= cpwm_pkg::ctrl_t'(`CPWM_RST_CONTROL);
			output_master_enable_r     <= `CPWM_RST_OUT_ENABLE;
			bus_control_register_one_r <= `CPWM_RST_BUS_CONTROL;
		end else begin
			if (wr_hit(req_r, `CPWM_OFF_CONTROL, access_en)) begin
				ctrl_r <= cpwm_pkg::ctrl_t'(wdata[10:0]);
			end
			if (wr_hit(req_r, `CPWM_OFF_OUT_ENABLE, access_en)) begin
				output_master_enable_r <= wdata[5:0];
			end
			if (wr_hit(req_r, `CPWM_OFF_BUS_CONTROL, access_en)) begin
				bus_control_register_one_r <= wdata;
			end
		end
	end

	// Both run bits must be set; a single run bit leaves the pair frozen.
	assign running    = ctrl_r.mode_sel && ctrl_r.ch3_run_bit && ctrl_r.ch4_run_bit;
	assign presc_mask = 8'((9'h001 << (2 * ctrl_r.prescaler_select)) - 9'h001);
	assign tick       = running && ((presc_r & presc_mask) == presc_mask);
	assign mode_rise  = ctrl_r.mode_sel && !mode_d_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_r  <= '0;
			mode_d_r <= 1'b0;
		end else begin
			presc_r  <= running ? presc_r + 8'h01 : 8'h00;
			mode_d_r <= ctrl_r.mode_sel;
		end
	end

	assign crest_start  = tick && main_up_r && (main_updown_counter_r == half_cycle_register_r);
	assign trough_start = tick && !offset_up_r && (offset_updown_counter_r == deadtime_value_register_r);
	assign sub_active   = (sub_phase_r != cpwm_pkg::SUB_IDLE);
	assign crest_end    = tick && (sub_phase_r == cpwm_pkg::SUB_CREST) && sub_up_r &&
	                      (deadtime_subcounter_r == upper_limit_register_r);
	assign trough_end   = tick && (sub_phase_r == cpwm_pkg::SUB_TROUGH) && !sub_up_r &&
	                      (deadtime_subcounter_r == 16'h0000);
	assign load_cmp     = (crest_end && ctrl_r.upd_crest) || (trough_end && ctrl_r.upd_trough);

	// Main counter: reload while ch3_run_bit is clear in the mode, else software write, then triangle between dead time and limit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_updown_counter_r <= `CPWM_RST_COUNT;
			main_up_r             <= 1'b1;
		end else if (ctrl_r.mode_sel && !ctrl_r.ch3_run_bit) begin
			main_updown_counter_r <= deadtime_value_register_r;
			main_up_r             <= 1'b1;
		end else if (wr_hit(req_r, `CPWM_OFF_MAIN_COUNT, access_en)) begin
			main_updown_counter_r <= wdata;
		end else if (tick) begin
			if (main_up_r && main_updown_counter_r == upper_limit_register_r) begin
				main_up_r             <= 1'b0;
				main_updown_counter_r <= main_updown_counter_r - 16'h0001;
			end else if (!main_up_r && main_updown_counter_r == deadtime_value_register_r) begin
				main_up_r             <= 1'b1;
				main_updown_counter_r <= main_updown_counter_r + 16'h0001;
			end else begin
				main_updown_counter_r <= main_up_r ? main_updown_counter_r + 16'h0001
				                                   : main_updown_counter_r - 16'h0001;
			end
		end
	end

	// Offset counter runs on the same tick, one dead time behind the main counter.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			offset_updown_counter_r <= `CPWM_RST_COUNT;
			offset_up_r             <= 1'b1;
		end else if (wr_hit(req_r, `CPWM_OFF_OFFSET_COUNT, access_en)) begin
			offset_updown_counter_r <= wdata;
			offset_up_r             <= 1'b1;
		end else if (tick) begin
			if (offset_up_r && offset_updown_counter_r == half_cycle_register_r) begin
				offset_up_r             <= 1'b0;
				offset_updown_counter_r <= offset_updown_counter_r - 16'h0001;
			end else if (!offset_up_r && offset_updown_counter_r == 16'h0000) begin
				offset_up_r             <= 1'b1;
				offset_updown_counter_r <= offset_updown_counter_r + 16'h0001;
			end else begin
				offset_updown_counter_r <= offset_up_r ? offset_updown_counter_r + 16'h0001
				                                       : offset_updown_counter_r - 16'h0001;
			end
		end
	end

	// Subcounter has no write path; it is parked at the limit while the pair is stopped.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deadtime_subcounter_r <= `CPWM_RST_COUNT;
			sub_up_r              <= 1'b0;
			sub_phase_r           <= cpwm_pkg::SUB_IDLE;
		end else if (!running) begin
			deadtime_subcounter_r <= upper_limit_register_r;
			sub_phase_r           <= cpwm_pkg::SUB_IDLE;
		end else if (tick) begin
			case (sub_phase_r)
				cpwm_pkg::SUB_IDLE: begin
					if (crest_start) begin
						sub_phase_r           <= cpwm_pkg::SUB_CREST;
						sub_up_r              <= 1'b0;
						deadtime_subcounter_r <= deadtime_subcounter_r - 16'h0001;
					end else if (trough_start) begin
						sub_phase_r           <= cpwm_pkg::SUB_TROUGH;
						sub_up_r              <= 1'b1;
						deadtime_subcounter_r <= deadtime_subcounter_r + 16'h0001;
					end
				end
				cpwm_pkg::SUB_CREST: begin
					if (crest_end) begin
						deadtime_subcounter_r <= 16'h0000;
						sub_phase_r           <= cpwm_pkg::SUB_IDLE;
					end else if (!sub_up_r && deadtime_subcounter_r == half_cycle_register_r) begin
						sub_up_r              <= 1'b1;
						deadtime_subcounter_r <= deadtime_subcounter_r + 16'h0001;
					end else begin
						deadtime_subcounter_r <= sub_up_r ? deadtime_subcounter_r + 16'h0001
						                                  : deadtime_subcounter_r - 16'h0001;
					end
				end
				cpwm_pkg::SUB_TROUGH: begin
					if (trough_end) begin
						deadtime_subcounter_r <= upper_limit_register_r;
						sub_phase_r           <= cpwm_pkg::SUB_IDLE;
					end else if (sub_up_r && deadtime_subcounter_r == deadtime_value_register_r) begin
						sub_up_r              <= 1'b0;
						deadtime_subcounter_r <= deadtime_subcounter_r - 16'h0001;
					end else begin
						deadtime_subcounter_r <= sub_up_r ? deadtime_subcounter_r + 16'h0001
						                                  : deadtime_subcounter_r - 16'h0001;
					end
				end
				default: sub_phase_r <= cpwm_pkg::SUB_IDLE;
			endcase
		end
	end

	// A phase-three buffer write arms the transfer; it fires only outside the dead-time interval.
	assign do_xfer = xfer_pend_r && !sub_active;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_pend_r <= 1'b0;
		end else if (wr_hit(req_r, `CPWM_OFF_DUTY_BUF3, access_en)) begin
			xfer_pend_r <= 1'b1;
		end else if (do_xfer) begin
			xfer_pend_r <= 1'b0;
		end
	end

	// Limit and half-cycle registers with their buffers and hidden stages, and the dead-time register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			upper_limit_register_r    <= `CPWM_RST_LIMIT;
			upper_limit_buffer_r      <= `CPWM_RST_LIMIT;
			upper_limit_stage_r       <= `CPWM_RST_LIMIT;
			deadtime_value_register_r <= `CPWM_RST_COUNT;
			half_cycle_register_r     <= `CPWM_RST_LIMIT;
			half_cycle_buffer_r       <= `CPWM_RST_LIMIT;
			half_cycle_stage_r        <= `CPWM_RST_LIMIT;
		end else begin
			if (wr_hit(req_r, `CPWM_OFF_UPPER_BUFFER, access_en)) begin
				upper_limit_buffer_r <= wdata;
			end
			if (wr_hit(req_r, `CPWM_OFF_HALF_BUFFER, access_en)) begin
				half_cycle_buffer_r <= wdata;
			end
			if (wr_hit(req_r, `CPWM_OFF_DEADTIME, access_en)) begin
				deadtime_value_register_r <= wdata;
			end
			if (do_xfer) begin
				upper_limit_stage_r <= upper_limit_buffer_r;
				half_cycle_stage_r  <= half_cycle_buffer_r;
			end
			if (mode_rise) begin
				upper_limit_register_r <= upper_limit_buffer_r;
				half_cycle_register_r  <= half_cycle_buffer_r;
				upper_limit_stage_r    <= upper_limit_buffer_r;
				half_cycle_stage_r     <= half_cycle_buffer_r;
			end else if (load_cmp) begin
				upper_limit_register_r <= upper_limit_stage_r;
				half_cycle_register_r  <= half_cycle_stage_r;
			end else begin
				if (wr_hit(req_r, `CPWM_OFF_UPPER_LIMIT, access_en)) begin
					upper_limit_register_r <= wdata;
				end
				if (wr_hit(req_r, `CPWM_OFF_HALF_CYCLE, access_en)) begin
					half_cycle_register_r <= wdata;
				end
			end
		end
	end

	// Initial inactive hold lasts until the offset counter first passes the dead time.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_hold_r <= 1'b1;
		end else if (mode_rise || !ctrl_r.mode_sel) begin
			init_hold_r <= 1'b1;
		end else if (offset_updown_counter_r > deadtime_value_register_r) begin
			init_hold_r <= 1'b0;
		end
	end

	// Toggle pin flips at each crest turn of the main counter.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			toggle_r <= 1'b0;
		end else if (!ctrl_r.mode_sel || !ctrl_r.period_toggle_enable) begin
			toggle_r <= 1'b0;
		end else if (tick && main_up_r && main_updown_counter_r == upper_limit_register_r) begin
			toggle_r <= ~toggle_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			logic pos_on;
			logic neg_on;
			logic [15:0] lo_duty;

			// Duty compare, buffer and hidden stage; the stage has no bus address.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					duty_cmp_r[g]   <= `CPWM_RST_COUNT;
					duty_buf_r[g]   <= `CPWM_RST_COUNT;
					duty_stage_r[g] <= `CPWM_RST_COUNT;
				end else begin
					if (wr_hit(req_r, 8'(`CPWM_OFF_DUTY_BUF1 + 4 * g), access_en)) begin
						duty_buf_r[g] <= wdata;
					end
					if (do_xfer) begin
						duty_stage_r[g] <= duty_buf_r[g];
					end
					if (mode_rise) begin
						duty_cmp_r[g]   <= duty_buf_r[g];
						duty_stage_r[g] <= duty_buf_r[g];
					end else if (load_cmp) begin
						duty_cmp_r[g] <= duty_stage_r[g];
					end else if (wr_hit(req_r, 8'(`CPWM_OFF_DUTY_CMP1 + 4 * g), access_en)) begin
						duty_cmp_r[g] <= wdata;
					end
				end
			end

			// During the dead-time interval both old and new duty take part; the off side wins.
			assign lo_duty = (duty_stage_r[g] < duty_cmp_r[g]) ? duty_stage_r[g] : duty_cmp_r[g];
			always_comb begin
				pos_on = offset_updown_counter_r > duty_cmp_r[g];
				neg_on = main_updown_counter_r < duty_cmp_r[g];
				if (sub_active) begin
					pos_on = pos_on && (offset_updown_counter_r > duty_stage_r[g]) &&
					         (deadtime_subcounter_r > lo_duty);
					neg_on = neg_on && (main_updown_counter_r < duty_stage_r[g]);
				end
				if (pos_on && neg_on) begin
					neg_on = 1'b0;
				end
			end

			// Levels are resolved in flip-flops; disabled pins and the initial hold show the inactive level.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pins_r[2*g]   <= 1'b0;
					pins_r[2*g+1] <= 1'b0;
				end else begin
					pins_r[2*g] <= (ctrl_r.mode_sel && !init_hold_r && output_master_enable_r[2*g] && pos_on)
					               == ctrl_r.positive_level_select;
					pins_r[2*g+1] <= (ctrl_r.mode_sel && !init_hold_r && output_master_enable_r[2*g+1] && neg_on)
					                 == ctrl_r.negative_level_select;
				end
			end
		end
	endgenerate

	assign phase1_positive_out = pins_r[0];
	assign phase1_negative_out = pins_r[1];
	assign phase2_positive_out = pins_r[2];
	assign phase2_negative_out = pins_r[3];
	assign phase3_positive_out = pins_r[4];
	assign phase3_negative_out = pins_r[5];
	assign period_toggle_pin   = toggle_r;

endmodule : complementary_three_phase_pwm

// >>> tb/cpwm_assertions.sv
// Checker tying bus answers and phase pins of the PWM block to their causes.
module cpwm_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        period_toggle_pin,
	input wire logic        phase1_positive_out,
	input wire logic        phase1_negative_out,
	input wire logic        phase2_positive_out,
	input wire logic        phase2_negative_out,
	input wire logic        phase3_positive_out,
	input wire logic        phase3_negative_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]     a_r;
	logic           w_r;
	logic           r_r;
	logic           acc_r;
	cpwm_pkg::ctrl_t ctl_r;
	logic [2:0]     pos_on;
	logic [2:0]     neg_on;
	logic           run;
	// The checker shadows control writes so that active levels are known.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_r   <= 1'b0;
			r_r   <= 1'b0;
			acc_r <= 1'b1;
			ctl_r <= '0;
		end else begin
			w_r <= hsel && hready && htrans[1] && hwrite;
			r_r <= hsel && hready && htrans[1] && !hwrite;
			a_r <= haddr[7:0];
			if (w_r && a_r == 8'h00) ctl_r <= hwdata[10:0];
			if (w_r && a_r == 8'h08) acc_r <= hwdata[13];
		end
	end
	assign pos_on = {3{ctl_r.positive_level_select}} ~^ {phase3_positive_out, phase2_positive_out, phase1_positive_out};
	assign neg_on = {3{ctl_r.negative_level_select}} ~^ {phase3_negative_out, phase2_negative_out, phase1_negative_out};
	assign run = ctl_r.ch3_run_bit && ctl_r.ch4_run_bit;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (!hresp && hreadyout)
		else $error("bus answer not ready okay");
	a_guard_read: assert property (
		r_r && !acc_r && a_r inside {8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h34, 8'h38} |-> hrdata == 32'h00000000)
		else $error("blocked register read not zero");
	a_hidden_none: assert property (r_r && a_r > 8'h40 |-> hrdata == 32'h00000000)
		else $error("read past the map not zero");
	a_p1_apart: assert property (ctl_r.mode_sel && $stable(ctl_r) |-> !(pos_on[0] && neg_on[0]))
		else $error("phase one legs overlap");
	a_p2_apart: assert property (ctl_r.mode_sel && $stable(ctl_r) |-> !(pos_on[1] && neg_on[1]))
		else $error("phase two legs overlap");
	a_p3_apart: assert property (ctl_r.mode_sel && $stable(ctl_r) |-> !(pos_on[2] && neg_on[2]))
		else $error("phase three legs overlap");
	a_idle_quiet: assert property (
		$past(hresetn) && !ctl_r.mode_sel && $stable(ctl_r) |-> (pos_on | neg_on) == 3'b000)
		else $error("phase pin active outside the mode");
	// The pin is cleared one cycle after the enable drops, so the quiet check starts a cycle later.
	a_toggle_off: assert property (!ctl_r.period_toggle_enable [*3] |-> $stable(period_toggle_pin))
		else $error("toggle pin moved while disabled");
	a_toggle_halt: assert property (!run [*2] |-> $stable(period_toggle_pin))
		else $error("toggle pin moved while halted");
	cover property (run && ctl_r.mode_sel && pos_on[0]);
	cover property (r_r && !acc_r);
	cover property ($changed(period_toggle_pin));
endmodule : cpwm_assertions

bind complementary_three_phase_pwm cpwm_assertions u_chk (.*);

// >>> tb/gate_driver_model.sv
// Gate-driver stand-in that counts positive-side switch-on events and shoot-through of the three legs.
module gate_driver_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        arm,
	input  wire logic [2:0]  pos_pin,
	input  wire logic [2:0]  neg_pin,
	output logic      [15:0] on_count,
	output logic      [15:0] shoot_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] pos_q;
	// Active-high drivers; counting waits for arm since pins idle high before levels are set.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pos_q       <= 3'b000;
			on_count    <= 16'h0000;
			shoot_count <= 16'h0000;
		end else if (arm) begin
			pos_q <= pos_pin;
			if (|(pos_pin & ~pos_q)) on_count <= on_count + 16'h0001;
			if (|(pos_pin & neg_pin)) shoot_count <= shoot_count + 16'h0001;
		end
	end
endmodule : gate_driver_model

// >>> tb/testbench.sv
// Register-level bench of the complementary PWM block.
`include "cpwm_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, arm = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [1:0] htrans = 2'b00;
	logic [2:0] pos, neg;
	logic tog, hreadyout, hresp;
	logic [15:0] on_count, shoot_count;
	int fails = 0, cmp_count = 0, cyc = 0, tog_n = 0;
	logic [7:0] sa [13] = '{8'h0C, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h38, 8'h3C, 8'h14, 8'h18, 8'h30};
	logic [15:0] sd [13] = '{16'h4, 16'h0, 16'h8, 16'hA, 16'hC, 16'h8, 16'hA, 16'h4, 16'h14, 16'h14, 16'h18, 16'h18, 16'hC};
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	always @(tog) tog_n++;
	complementary_three_phase_pwm DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .period_toggle_pin(tog), .phase1_positive_out(pos[0]), .phase1_negative_out(neg[0]),
		.phase2_positive_out(pos[1]), .phase2_negative_out(neg[1]), .phase3_positive_out(pos[2]),
		.phase3_negative_out(neg[2]));
	gate_driver_model u_gate (.clk(hclk), .rstn(hresetn), .arm(arm), .pos_pin(pos), .neg_pin(neg),
		.on_count(on_count), .shoot_count(shoot_count));
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Single AHB-Lite transfer; the data phase ends when hready is seen high again.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 16'h0000);
		chk($sformatf("register %h", a), e, q);
	endtask : rc
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rc(`CPWM_OFF_BUS_CONTROL, 32'h2000);
		rc(`CPWM_OFF_UPPER_LIMIT, 32'hFFFF);
		xfer(1'b1, `CPWM_OFF_SUBCOUNT, 16'h1234);
		rc(`CPWM_OFF_SUBCOUNT, 32'h0000FFFF);
		rc(8'h80, 32'h0);
		xfer(1'b1, `CPWM_OFF_BUS_CONTROL, 16'h0000);
		xfer(1'b1, `CPWM_OFF_DUTY_CMP1, 16'h0005);
		xfer(1'b1, `CPWM_OFF_DUTY_BUF1, 16'h0007);
		rc(`CPWM_OFF_DUTY_CMP1, 32'h0);
		rc(`CPWM_OFF_DUTY_BUF1, 32'h7);
		xfer(1'b1, `CPWM_OFF_BUS_CONTROL, 16'h2000);
		rc(`CPWM_OFF_DUTY_CMP1, 32'h0);
		// Setup order keeps the phase-three buffer last and levels ahead of the mode bit.
		for (int i = 0; i < 13; i++) xfer(1'b1, sa[i], sd[i]);
		xfer(1'b1, `CPWM_OFF_CONTROL, 16'h00F8);
		xfer(1'b1, `CPWM_OFF_CONTROL, 16'h00FC);
		xfer(1'b1, `CPWM_OFF_MAIN_COUNT, 16'h0009);
		rc(`CPWM_OFF_MAIN_COUNT, 32'h4);
		xfer(1'b1, `CPWM_OFF_OUT_ENABLE, 16'h003F);
		arm <= 1'b1;
		xfer(1'b1, `CPWM_OFF_CONTROL, 16'h00FF);
		repeat (400) @(posedge hclk);
		chk("shoot through", 32'h0, {16'h0000, shoot_count});
		chk("pulses seen", 32'h1, {31'h0, on_count > 16'h0005});
		chk("toggles seen", 32'h1, {31'h0, tog_n > 3});
		xfer(1'b0, `CPWM_OFF_MAIN_COUNT, 16'h0000);
		chk("main in range", 32'h1, {31'h0, q >= 32'h4 && q <= 32'h18});
		// A write while running would leave the subcounter far outside its range if it landed.
		xfer(1'b1, `CPWM_OFF_SUBCOUNT, 16'h1234);
		xfer(1'b0, `CPWM_OFF_SUBCOUNT, 16'h0000);
		chk("sub in range", 32'h1, {31'h0, q <= 32'h18});
		xfer(1'b1, `CPWM_OFF_CONTROL, 16'h00FC);
		rc(`CPWM_OFF_MAIN_COUNT, 32'h4);
		xfer(1'b0, `CPWM_OFF_OFFSET_COUNT, 16'h0000);
		repeat (10) @(posedge hclk);
		rc(`CPWM_OFF_OFFSET_COUNT, q);
		final_report();
	end
endmodule : testbench
